// [verilog/wdog_ctrl.sv]
// Watchdog control block: APB register file, counter, refresh and unlock sequences, forced reset.
// Assumes chip mode levels and the vector fetch pulse are synchronous to pclk, and that the
// chip answers the forced reset request by pulsing sys_reset (any reset other than power-on).
module wdog_ctrl (
  // Clock and power-on reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [wdog_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // Chip state
  input  wire logic                        sys_reset,
  input  wire logic                        debug_mode,
  input  wire logic                        wait_mode,
  input  wire logic                        stop_mode,
  input  wire logic                        vector_fetch,
  // Requests to the chip
  output logic                             irq,
  output logic                             wdog_reset_req
);
  import wdog_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_REF, S_UNL} seq_e;
  typedef enum logic [1:0] {F_IDLE, F_WAIT_VEC, F_DELAY, F_FIRE} force_e;

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        rst_req_q;
  logic [7:0]  cfg_q [6];
  logic [5:0]  once_q;
  logic [15:0] cnt_q;
  logic [7:0]  pre_q;
  logic [7:0]  hi_q;
  logic        hi_v_q;
  seq_e        seq_q;
  seq_e        seq_d;
  logic [3:0]  gap_q;
  logic        unl_open_q;
  logic [6:0]  unl_cnt_q;
  force_e      force_q;
  logic [6:0]  dly_q;
  logic [7:0]  stat_q;
  logic [7:0]  stat_set;
  logic [7:0]  mask_q;

  reg_e        sel;
  logic [2:0]  ci;
  logic        done;
  logic        wr;
  logic        rd;
  logic        answer;
  logic [7:0]  rd_byte;
  cs1_s        cs1;
  cs2_s        cs2;
  logic [7:0]  wval;
  logic        cfg_w;
  logic        cfg_open;
  logic        cfg_bad;
  logic        flag_clr;
  logic        run;
  logic        tick;
  logic        match;
  logic        timeout;
  logic [15:0] word;
  logic        word_v;
  logic        seq_bad;
  logic        refresh;
  logic        unlock;
  logic        early;
  logic        refresh_ok;
  logic        illegal;
  logic        trig;
  logic        wd_int_set;

  // Maps an APB byte address to a register; misaligned or unmapped addresses give R_NONE.
  function automatic reg_e decode(input logic [ADDR_W-1:0] a);
    logic [13:0] off;
    off = a[ADDR_W-1:2] - IDX_CS1;
    if (a[1:0] != 2'b00 || a[ADDR_W-1:2] < IDX_CS1 || a[ADDR_W-1:2] > IDX_MASK) begin
      return R_NONE;
    end
    return reg_e'(off[3:0]);
  endfunction

  // Maps a configuration register to its slot in the configuration storage.
  function automatic logic [2:0] cfg_idx(input reg_e r);
    unique case (r)
      R_CS1:   return 3'd0;
      R_CS2:   return 3'd1;
      R_TOH:   return 3'd2;
      R_TOL:   return 3'd3;
      R_WINH:  return 3'd4;
      default: return 3'd5;
    endcase
  endfunction

  // Bus decode and field views.
  always_comb begin
    sel    = decode(paddr);
    ci     = cfg_idx(sel);
    answer = psel & penable & ~pready_q;
    done   = psel & penable & pready_q;
    wr     = done & pwrite;
    rd     = done & ~pwrite;
    cs1    = cs1_s'(cfg_q[0]);
    cs2    = cs2_s'(cfg_q[1]);
  end

  // Read data multiplexer.
  always_comb begin
    unique case (sel)
      R_CS1, R_CS2, R_TOH, R_TOL, R_WINH, R_WINL: rd_byte = cfg_q[ci] & CFG_RMASK[ci];
      R_CNTH:  rd_byte = cnt_q[15:8];
      R_CNTL:  rd_byte = cnt_q[7:0];
      R_STAT:  rd_byte = stat_q;
      R_MASK:  rd_byte = mask_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // APB answer: one wait state, then pready with data and error for unmapped addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= answer;
      pslverr_q <= answer & (sel == R_NONE);
      if (answer) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // A locked register may change only while the unlock window is open; otherwise a change
  // is illegal when updates are not allowed, and silently ignored when they are.
  always_comb begin
    cfg_w    = wr & (sel inside {R_CS1, R_CS2, R_TOH, R_TOL, R_WINH, R_WINL});
    wval     = pwdata[7:0] & CFG_WMASK[ci];
    cfg_open = ~once_q[ci] | unl_open_q;
    cfg_bad  = cfg_w & ~cfg_open & ~cs1.upd & (wval != (cfg_q[ci] & CFG_WMASK[ci]));
    flag_clr = wr & (sel == R_CS2) & pwdata[CS2_FLAG_BIT];
  end

  // Configuration storage; the test field survives every reset but power-on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        cfg_q[i] <= CFG_RST[i];
      end
      once_q <= 6'h00;
    end else if (sys_reset) begin
      for (int i = 0; i < 6; i++) begin
        cfg_q[i] <= CFG_RST[i];
      end
      cfg_q[0][TST_MSB:TST_LSB] <= cfg_q[0][TST_MSB:TST_LSB];
      once_q <= 6'h00;
    end else begin
      if (cfg_w && cfg_open) begin
        cfg_q[ci]  <= (cfg_q[ci] & ~CFG_WMASK[ci]) | wval;
        once_q[ci] <= 1'b1;
      end
      // The interrupt flag is set by hardware and cleared by writing one; the set wins.
      if (wd_int_set) begin
        cfg_q[1][CS2_FLAG_BIT] <= 1'b1;
      end else if (flag_clr) begin
        cfg_q[1][CS2_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // Run qualification, prescaler tick and timeout compare.
  always_comb begin
    run  = cs1.en & ~(debug_mode & ~cs1.dbg) & ~(wait_mode & ~cs1.wt) & ~(stop_mode & ~cs1.stp);
    tick = ~cs2.pres | (pre_q == PRESCALE_LAST);
    unique case (cs1.tst)
      TST_LOW:          match = (cnt_q[7:0] == cfg_q[3]);
      TST_HIGH:         match = (cnt_q[15:8] == cfg_q[2]);
      TST_OFF, TST_USER: match = (cnt_q == {cfg_q[2], cfg_q[3]});
    endcase
    timeout = run & match;
  end

  // Watchdog counter; it holds at the timeout value until refreshed or reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {CNT_RST, CNT_RST};
      pre_q <= 8'h00;
    end else if (sys_reset || refresh_ok) begin
      cnt_q <= {CNT_RST, CNT_RST};
      pre_q <= 8'h00;
    end else if (run) begin
      pre_q <= pre_q + 8'h01;
      if (tick && !match) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Key words are assembled from a high byte write followed by a low byte write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q   <= 8'h00;
      hi_v_q <= 1'b0;
    end else if (sys_reset) begin
      hi_v_q <= 1'b0;
    end else if (wr && sel == R_CNTH) begin
      hi_q   <= pwdata[7:0];
      hi_v_q <= 1'b1;
    end else if (wr && sel == R_CNTL) begin
      hi_v_q <= 1'b0;
    end
  end

  // Sequence checker: any word other than the expected key, or a late second key, is illegal.
  always_comb begin
    word    = {hi_q, pwdata[7:0]};
    word_v  = wr & (sel == R_CNTL) & hi_v_q;
    seq_d   = seq_q;
    refresh = 1'b0;
    unlock  = 1'b0;
    seq_bad = wr & (sel == R_CNTL) & ~hi_v_q;
    unique case (seq_q)
      S_IDLE: begin
        if (word_v) begin
          if (word == REFRESH_KEY1) begin
            seq_d = S_REF;
          end else if (word == UNLOCK_KEY1) begin
            seq_d = S_UNL;
          end else begin
            seq_bad = 1'b1;
          end
        end
      end
      S_REF: begin
        if (word_v) begin
          seq_d   = S_IDLE;
          refresh = (word == REFRESH_KEY2);
          seq_bad = (word != REFRESH_KEY2);
        end else if (gap_q == SEQ_GAP_LAST) begin
          seq_d   = S_IDLE;
          seq_bad = 1'b1;
        end
      end
      S_UNL: begin
        if (word_v) begin
          seq_d   = S_IDLE;
          unlock  = (word == UNLOCK_KEY2) & cs1.upd;
          seq_bad = (word != UNLOCK_KEY2) | ~cs1.upd;
        end else if (gap_q == SEQ_GAP_LAST) begin
          seq_d   = S_IDLE;
          seq_bad = 1'b1;
        end
      end
    endcase
    early      = refresh & cs2.win & (cnt_q < {cfg_q[4], cfg_q[5]});
    refresh_ok = refresh & ~early;
    illegal    = cfg_bad | seq_bad | early;
    trig       = (timeout | illegal) & (force_q == F_IDLE);
    wd_int_set = trig & cs1.ie;
  end

  // Sequence state and the gap counter between the two key words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= S_IDLE;
      gap_q <= 4'h0;
    end else if (sys_reset) begin
      seq_q <= S_IDLE;
      gap_q <= 4'h0;
    end else begin
      seq_q <= seq_d;
      gap_q <= (seq_q == S_IDLE) ? 4'h0 : gap_q + 4'h1;
    end
  end

  // Unlock window: open for a fixed number of bus clocks after a good unlock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_open_q <= 1'b0;
      unl_cnt_q  <= 7'h00;
    end else if (sys_reset) begin
      unl_open_q <= 1'b0;
      unl_cnt_q  <= 7'h00;
    end else if (unlock) begin
      unl_open_q <= 1'b1;
      unl_cnt_q  <= 7'h00;
    end else if (unl_open_q) begin
      unl_cnt_q <= unl_cnt_q + 7'h01;
      if (unl_cnt_q == UNLOCK_LAST) begin
        unl_open_q <= 1'b0;
      end
    end
  end

  // Forced reset sequencer; the request stays high until the chip resets the block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_q   <= F_IDLE;
      dly_q     <= 7'h00;
      rst_req_q <= 1'b0;
    end else if (sys_reset) begin
      force_q   <= F_IDLE;
      dly_q     <= 7'h00;
      rst_req_q <= 1'b0;
    end else begin
      unique case (force_q)
        F_IDLE: begin
          if (trig && cs1.ie) begin
            force_q <= F_WAIT_VEC;
          end else if (trig) begin
            force_q   <= F_FIRE;
            rst_req_q <= 1'b1;
          end
        end
        F_WAIT_VEC: begin
          if (vector_fetch) begin
            force_q <= F_DELAY;
            dly_q   <= 7'h00;
          end
        end
        F_DELAY: begin
          dly_q <= dly_q + 7'h01;
          if (dly_q == DELAY_LAST) begin
            force_q   <= F_FIRE;
            rst_req_q <= 1'b1;
          end
        end
        F_FIRE: begin
          force_q <= F_FIRE;
        end
      endcase
    end
  end

  // Sticky event status, cleared by reading it; a new event in the read cycle survives.
  always_comb begin
    stat_set             = 8'h00;
    stat_set[ST_REFRESH] = refresh_ok;
    stat_set[ST_UNLOCK]  = unlock;
    stat_set[ST_WDINT]   = wd_int_set;
  end

  // Status, mask and the interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= STAT_RST;
      mask_q <= MASK_RST;
      irq_q  <= 1'b0;
    end else if (sys_reset) begin
      stat_q <= STAT_RST;
      mask_q <= MASK_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (rd && sel == R_STAT) ? stat_set : (stat_q | stat_set);
      if (wr && sel == R_MASK) begin
        mask_q <= pwdata[7:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign irq            = irq_q;
  assign wdog_reset_req = rst_req_q;

endmodule

// [verilog/wdog_pkg.sv]
// Constants, register map and field layouts of the watchdog control block.
// Assumes a 32-bit APB master; each byte register sits in the low byte of one aligned word.
package wdog_pkg;

  // APB address width; byte address of a register is four times its index.
  localparam int unsigned ADDR_W = 16;

  // Register indices as printed, plus two of our own for interrupt status and mask.
  localparam logic [13:0] IDX_CS1  = 14'h3030;
  localparam logic [13:0] IDX_CS2  = 14'h3031;
  localparam logic [13:0] IDX_CNTH = 14'h3032;
  localparam logic [13:0] IDX_CNTL = 14'h3033;
  localparam logic [13:0] IDX_TOH  = 14'h3034;
  localparam logic [13:0] IDX_TOL  = 14'h3035;
  localparam logic [13:0] IDX_WINH = 14'h3036;
  localparam logic [13:0] IDX_WINL = 14'h3037;
  localparam logic [13:0] IDX_STAT = 14'h3038;
  localparam logic [13:0] IDX_MASK = 14'h3039;

  // Register selector; the order follows the index order above.
  typedef enum logic [3:0] {
    R_CS1, R_CS2, R_CNTH, R_CNTL, R_TOH, R_TOL, R_WINH, R_WINL, R_STAT, R_MASK, R_NONE
  } reg_e;

  // Reset values of the six configuration registers (control 1, control 2, timeout, window).
  localparam logic [7:0] CS1_RST  = 8'h80;
  localparam logic [7:0] CS2_RST  = 8'h01;
  localparam logic [7:0] TOH_RST  = 8'h09;
  localparam logic [7:0] TOL_RST  = 8'hc4;
  localparam logic [7:0] WIN_RST  = 8'h00;
  localparam logic [7:0] CFG_RST [6] = '{CS1_RST, CS2_RST, TOH_RST, TOL_RST, WIN_RST, WIN_RST};
  // Bits that a write stores, and bits that read back (reserved bits read zero).
  localparam logic [7:0] CFG_WMASK [6] = '{8'hff, 8'h93, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] CFG_RMASK [6] = '{8'hff, 8'hd3, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h04;

  // Field positions.
  localparam int unsigned TST_LSB      = 3;
  localparam int unsigned TST_MSB      = 4;
  localparam int unsigned CS2_FLAG_BIT = 6;
  localparam int unsigned ST_REFRESH   = 0;
  localparam int unsigned ST_UNLOCK    = 1;
  localparam int unsigned ST_WDINT     = 2;

  // Fast test select codes.
  localparam logic [1:0] TST_OFF  = 2'b00;
  localparam logic [1:0] TST_USER = 2'b01;
  localparam logic [1:0] TST_LOW  = 2'b10;
  localparam logic [1:0] TST_HIGH = 2'b11;

  // Key words written to the counter registers, high byte first.
  localparam logic [15:0] REFRESH_KEY1 = 16'ha602;
  localparam logic [15:0] REFRESH_KEY2 = 16'hb480;
  localparam logic [15:0] UNLOCK_KEY1  = 16'hc520;
  localparam logic [15:0] UNLOCK_KEY2  = 16'hd928;

  // Timing in bus clocks.
  localparam int unsigned SEQ_GAP_CLKS     = 16;
  localparam int unsigned UNLOCK_CLKS      = 128;
  localparam int unsigned FORCE_DELAY_CLKS = 128;
  localparam logic [3:0]  SEQ_GAP_LAST     = 4'(SEQ_GAP_CLKS - 1);
  localparam logic [6:0]  UNLOCK_LAST      = 7'(UNLOCK_CLKS - 1);
  localparam logic [6:0]  DELAY_LAST       = 7'(FORCE_DELAY_CLKS - 1);
  localparam logic [7:0]  PRESCALE_LAST    = 8'hff;

  // Field views of the two control registers.
  typedef struct packed {
    logic       en;
    logic       ie;
    logic       upd;
    logic [1:0] tst;
    logic       dbg;
    logic       wt;
    logic       stp;
  } cs1_s;

  typedef struct packed {
    logic       win;
    logic       flag;
    logic       rsv5;
    logic       pres;
    logic [1:0] rsv32;
    logic [1:0] clk_sel;
  } cs2_s;

endpackage

// [tb/wdog_ctrl_props.sv]
// Checker for the watchdog control block, watching only its ports.
// Assumes a single pclk domain and that presetn is the power-on reset.
module wdog_ctrl_props (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [wdog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  input wire logic [31:0]                 prdata,
  input wire logic                        pslverr,
  // Chip state and requests
  input wire logic                        sys_reset,
  input wire logic                        debug_mode,
  input wire logic                        wait_mode,
  input wire logic                        stop_mode,
  input wire logic                        vector_fetch,
  input wire logic                        irq,
  input wire logic                        wdog_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import wdog_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus timing, read data shape and refusals.
  a_ready_one_wait: assert property ($rose(penable) |-> !pready ##1 pready) else $error("pready not one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  a_err_reads_zero: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error response");
  // Forced reset and interrupt ordering.
  a_req_holds: assert property (wdog_reset_req && !sys_reset |=> wdog_reset_req)
    else $error("reset request dropped");
  a_sys_clears: assert property (sys_reset |=> !wdog_reset_req && !irq) else $error("outputs not cleared");
  a_irq_first: assert property ($rose(irq) |-> !wdog_reset_req)
    else $error("irq after reset request");
  a_fetch_delay: assert property (vector_fetch && irq |-> ##129 $rose(wdog_reset_req))
    else $error("reset not 128 clocks after fetch");

  // Main scenarios.
  c_fetch: cover property (vector_fetch && irq);
  c_req: cover property ($rose(wdog_reset_req));
  c_err: cover property (pslverr);
endmodule

bind wdog_ctrl wdog_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sys_reset(sys_reset), .debug_mode(debug_mode), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .vector_fetch(vector_fetch), .irq(irq), .wdog_reset_req(wdog_reset_req));

// [tb/watchdog_control_and_map_tb_top.sv]
// Self-checking bench for the watchdog control block over APB.
// Assumes the checker is bound to the design; the bench drives every port itself.
module watchdog_control_and_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wdog_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic              sys_reset, debug_mode, wait_mode, stop_mode, vector_fetch, irq, wdog_reset_req;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv, seed;
  logic [7:0]        a, cs;
  int                n_fail, total_checks, cyc, t0;
  localparam logic [13:0] RIDX [9] = '{IDX_CS1, IDX_CS2, IDX_CNTH, IDX_TOH, IDX_TOL, IDX_WINH, IDX_WINL,
                                       IDX_STAT, IDX_MASK};
  localparam logic [7:0]  RVAL [9] = '{CS1_RST, CS2_RST, CNT_RST, TOH_RST, TOL_RST, WIN_RST, WIN_RST,
                                       STAT_RST, MASK_RST};

  wdog_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sys_reset(sys_reset), .debug_mode(debug_mode), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .vector_fetch(vector_fetch), .irq(irq), .wdog_reset_req(wdog_reset_req));

  // Free-running 40 MHz bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Cycle ceiling that cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  // Pseudo-random step from a fixed seed.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Counter value at which each test select code fires.
  function automatic int trig_at(input logic [1:0] code);
    if (code == TST_LOW) return int'(TOL_RST);
    if (code == TST_HIGH) return int'(TOH_RST) * 256;
    return int'({TOH_RST, TOL_RST});
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; held until pready is seen high at the taking edge.
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after the edge are those the edge sampled; only the cycle ceiling ends a hang.
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rdv, exp);
  endtask

  task automatic wait_req(input int n);
    int i;
    i = 0;
    @(negedge pclk);
    while (wdog_reset_req !== 1'b1 && i < n) begin
      @(negedge pclk);
      i++;
    end
    // A request that never comes is a mismatch and ends the run.
    if (wdog_reset_req !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic sreset();
    @(posedge pclk);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
  endtask

  task automatic preset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {psel, penable, pwrite, sys_reset, debug_mode, wait_mode, stop_mode, vector_fetch} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    seed = 32'd54239;
    preset();
    // Reset values and an unmapped address.
    for (int i = 0; i < 9; i++) rchk("reset value", RIDX[i], {24'h0, RVAL[i]});
    apb(1'b0, 14'h3040, 8'h00);
    chk("unmapped err", errv, 1'b1);
    // Each test select code fires at its own count; the field survives a system reset.
    for (int c = 0; c < 4; c++) begin
      preset();
      apb(1'b1, IDX_CS1, 8'h80 | 8'(c << TST_LSB));
      wait_req(2700);
      chk("trigger time", 32'((cyc - t0) >= trig_at(2'(c)) - 6 && (cyc - t0) <= trig_at(2'(c)) + 6), 1);
      chk("no irq", irq, 1'b0);
      sreset();
      rchk("cs1 after sys reset", IDX_CS1, 32'h80 | 32'(c << TST_LSB));
    end
    preset();
    // Enable and low-power mode bits decide whether the counter advances.
    for (int i = 0; i < 7; i++) begin
      sreset();
      cs = (i == 6) ? 8'h00 : (8'h80 | (i[0] ? (8'h04 >> (i / 2)) : 8'h00));
      apb(1'b1, IDX_CS1, cs);
      debug_mode <= (i / 2 == 0);
      wait_mode <= (i / 2 == 1);
      stop_mode <= (i / 2 == 2);
      apb(1'b0, IDX_CNTL, 8'h00);
      a = rdv[7:0];
      apb(1'b0, IDX_CNTL, 8'h00);
      chk("cnt step", 32'(8'(rdv[7:0] - a)), (i[0] && i < 6) ? 32'd4 : 32'd0);
      chk("counter runs", 32'(rdv[7:0] != a), 32'(i[0] && i < 6));
    end
    {debug_mode, wait_mode, stop_mode} <= 3'b000;
    // Locked configuration change forces a reset.
    sreset();
    apb(1'b1, IDX_CS1, 8'h80);
    apb(1'b1, IDX_TOH, 8'h05);
    @(negedge pclk);
    chk("first write", wdog_reset_req, 1'b0);
    apb(1'b1, IDX_TOH, 8'h06);
    wait_req(4);
    chk("locked write", wdog_reset_req, 1'b1);
    // Updates only inside the window after a correct unlock.
    sreset();
    apb(1'b1, IDX_CS1, 8'ha0);
    apb(1'b1, IDX_TOH, 8'h20);
    apb(1'b1, IDX_TOH, 8'h30);
    rchk("ignored write", IDX_TOH, 32'h20);
    apb(1'b1, IDX_CNTH, UNLOCK_KEY1[15:8]);
    apb(1'b1, IDX_CNTL, UNLOCK_KEY1[7:0]);
    apb(1'b1, IDX_CNTH, UNLOCK_KEY2[15:8]);
    apb(1'b1, IDX_CNTL, UNLOCK_KEY2[7:0]);
    rchk("unlock status", IDX_STAT, 32'h02);
    seed = xs(seed);
    a = seed[7:0] & 8'h7f | 8'h10;
    apb(1'b1, IDX_TOH, a);
    rchk("window write", IDX_TOH, {24'h0, a});
    repeat (130) @(posedge pclk);
    apb(1'b1, IDX_TOH, 8'h05);
    rchk("late write", IDX_TOH, {24'h0, a});
    apb(1'b1, IDX_CNTH, REFRESH_KEY1[15:8]);
    apb(1'b1, IDX_CNTL, REFRESH_KEY1[7:0]);
    apb(1'b1, IDX_CNTH, REFRESH_KEY2[15:8]);
    apb(1'b1, IDX_CNTL, REFRESH_KEY2[7:0]);
    rchk("refresh status", IDX_STAT, 32'h01);
    rchk("cnt high cleared", IDX_CNTH, 32'h0);
    chk("no reset yet", wdog_reset_req, 1'b0);
    // Second key word too late is illegal.
    apb(1'b1, IDX_CNTH, UNLOCK_KEY1[15:8]);
    apb(1'b1, IDX_CNTL, UNLOCK_KEY1[7:0]);
    repeat (20) @(posedge pclk);
    apb(1'b1, IDX_CNTH, UNLOCK_KEY2[15:8]);
    apb(1'b1, IDX_CNTL, UNLOCK_KEY2[7:0]);
    wait_req(4);
    chk("slow unlock", wdog_reset_req, 1'b1);
    // A refresh before the window value is reached is illegal in window mode.
    sreset();
    apb(1'b1, IDX_CS2, 8'h81);
    apb(1'b1, IDX_WINH, 8'h08);
    apb(1'b1, IDX_CNTH, REFRESH_KEY1[15:8]);
    apb(1'b1, IDX_CNTL, REFRESH_KEY1[7:0]);
    apb(1'b1, IDX_CNTH, REFRESH_KEY2[15:8]);
    apb(1'b1, IDX_CNTL, REFRESH_KEY2[7:0]);
    wait_req(4);
    chk("early refresh", wdog_reset_req, 1'b1);
    // Interrupt masked, unmasked, cleared, then the delayed reset.
    sreset();
    apb(1'b1, IDX_MASK, 8'h00);
    apb(1'b1, IDX_TOH, 8'h00);
    apb(1'b1, IDX_TOL, 8'h80);
    apb(1'b1, IDX_CS1, 8'hc0);
    repeat (200) @(posedge pclk);
    chk("masked irq", irq, 1'b0);
    chk("delayed req", wdog_reset_req, 1'b0);
    rchk("flag", IDX_CS2, 32'h41);
    apb(1'b1, IDX_MASK, 8'h04);
    repeat (2) @(posedge pclk);
    chk("irq up", irq, 1'b1);
    // The vector fetch comes while the interrupt is still pending; the delay counts from its edge.
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
    rchk("stat", IDX_STAT, 32'h04);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    repeat (121) @(posedge pclk);
    #1 chk("req before 128", wdog_reset_req, 1'b0);
    @(posedge pclk);
    #1 chk("req at 128", wdog_reset_req, 1'b1);
    end_of_test();
  end
endmodule
